/* File: shared/ets_pkg.sv */
/*
 holds shared constants and types of the timed output scheduler.
 assumes nothing of its surroundings.
*/
package ets_pkg;
    // process image lengths
    localparam logic [7:0] IN_LEN      = 8'h04;
    localparam logic [7:0] OUT_LEN_S   = 8'h14;
    localparam logic [7:0] OUT_LEN_L   = 8'h3C;
    localparam int         ENTRY_BYTES = 4;
    localparam int         SLOTS_S     = 5;
    // diagnostic record
    localparam int         DIAG_BYTES  = 20;
    localparam int         DIAG_SHORT  = 4;
    localparam int         DIAG_TS_POS = 16;
    localparam logic [4:0] DIAG_MOD_AT = 5'h01;
    localparam logic [4:0] DIAG_CHT_AT = 5'h04;
    localparam logic [4:0] DIAG_NCH_AT = 5'h06;
    localparam logic [4:0] DIAG_NBT_AT = 5'h05;
    localparam logic [3:0] MOD_CLASS   = 4'hF;
    localparam logic       MOD_CH_INFO = 1'b1;
    localparam logic [6:0] CH_KIND     = 7'h72;
    localparam logic [7:0] NUM_BITS    = 8'h00;
    localparam logic [7:0] NUM_CH      = 8'h02;
    // sequence byte fields
    localparam int         SEQ_LAST_BIT = 6;
    localparam logic [7:0] SEQ_NUM_MASK = 8'h3F;
    // queue state byte fields
    localparam int         QS_LAST_BIT = 7;
    localparam int         QS_BUSY_BIT = 1;
    localparam int         QS_FULL_BIT = 0;
    // queue geometry
    localparam int         Q_DEPTH = 16;
    localparam int         Q_WIDTH = 32;

    // one queued entry, control byte first
    typedef struct packed {
        logic        lvl0;
        logic        lvl1;
        logic        en0;
        logic        en1;
        logic [3:0]  rsv;
        logic [7:0]  seq;
        logic [15:0] stamp;
    } entry_s;

    // input image status bytes
    typedef struct packed {
        logic [7:0] last_accepted_sequence;
        logic [7:0] next_expected_sequence;
        logic [7:0] queue_state_byte;
        logic [7:0] pending_entry_count;
    } status_s;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_WAIT  = 2'b01,
        S_APPLY = 2'b11
    } sched_e;
endpackage : ets_pkg

/* File: src/ets_fifo.sv */
/*
 holds a flip-flop fifo with valid and ready on both sides.
 assumes one clock and a synchronous active-low reset copy.
*/
`timescale 1ns/1ps
`default_nettype none
module ets_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    // honest full and empty from the count
    assign o_in_ready  = (cnt_ff < (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data  = mem_ff[rd_ff];
    assign o_count     = cnt_ff;

    // storage write
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= i_in_data;
        end
    end

    // pointers and count
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= push ? wr_ff + 1'b1 : wr_ff;
            rd_ff  <= pop ? rd_ff + 1'b1 : rd_ff;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ets_fifo
`default_nettype wire

/* File: src/ets_diag.sv */
/*
 holds the read-only diagnostic record with its captured ticker.
 assumes one clock and a synchronous active-low reset copy.
*/
`timescale 1ns/1ps
`default_nettype none
module ets_diag (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_gen,
    input  wire logic [31:0] i_ticker,
    input  wire logic        i_short,
    input  wire logic [4:0]  i_idx,
    output logic [7:0]       o_byte
);
    logic [31:0] stamp_ff;
    logic [7:0]  byte_ff;
    wire  [4:0]  ts_off = i_idx - 5'(ets_pkg::DIAG_TS_POS);
    wire  [4:0]  limit  = i_short ? 5'(ets_pkg::DIAG_SHORT)
                                  : 5'(ets_pkg::DIAG_BYTES);
    logic [7:0]  sel;

    // byte selection; reserved and fault bytes read zero
    always_comb begin
        sel = 8'h00;
        if (i_idx < limit) begin
            if (i_idx == ets_pkg::DIAG_MOD_AT) begin
                sel = {3'h0, ets_pkg::MOD_CH_INFO, ets_pkg::MOD_CLASS};
            end else if (i_idx == ets_pkg::DIAG_CHT_AT) begin
                sel = {1'b0, ets_pkg::CH_KIND};
            end else if (i_idx == ets_pkg::DIAG_NBT_AT) begin
                sel = ets_pkg::NUM_BITS;
            end else if (i_idx == ets_pkg::DIAG_NCH_AT) begin
                sel = ets_pkg::NUM_CH;
            end else if (i_idx >= 5'(ets_pkg::DIAG_TS_POS)) begin
                sel = stamp_ff[8*ts_off[1:0] +: 8];
            end
        end
    end

    // ticker capture at generation and registered read
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stamp_ff <= 32'h0000_0000;
            byte_ff  <= 8'h00;
        end else begin
            stamp_ff <= i_gen ? i_ticker : stamp_ff;
            byte_ff  <= sel;
        end
    end
    assign o_byte = byte_ff;
endmodule : ets_diag
`default_nettype wire

/* File: src/ets_sched.sv */
/*
 holds the top of the two-channel timed output scheduler: entry intake,
 queue, stamp matching, output drive, status image and diagnostics.
 assumes a head module that supplies a microsecond ticker and writes
 entries as whole 32-bit words through the output image port.
*/
// What this block does
// - input image length fixed at four bytes
// - output image length 14h or 3Ch
// - four bytes per entry, five per 14h image, 15 per 3Ch
// - written entries pushed straight into queue
// - outputs follow levels only once enabled
// - bit 7 drives output 0, bit 6 output 1
// - apply entry when ticker reaches its stamp
// - entries applied strictly first in, first out
// - input image reports four queue status bytes
// - no interrupts, diagnostics by record read only
// - full record, first four bytes as short record
// - module class 1111b, bit 4 channel info
// - channel kind 72h, bit 7 zero
// - two channels, zero diagnostic bits each
// - capture 32-bit ticker into record tail
`timescale 1ns/1ps
`default_nettype none
module ets_sched #(
    parameter bit LONG_VARIANT = 1'b0,
    parameter int Q_DEPTH      = ets_pkg::Q_DEPTH
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_entry_wr,
    input  wire logic [31:0] i_entry_data,
    output logic             o_entry_ready,
    input  wire logic [31:0] i_us_ticker,
    output logic             o_do0,
    output logic             o_do1,
    output logic [31:0]      o_input_image,
    output logic [7:0]       o_input_image_length,
    output logic [7:0]       o_output_image_length,
    input  wire logic        i_diag_gen,
    input  wire logic        i_diag_short,
    input  wire logic [4:0]  i_diag_idx,
    output logic [7:0]       o_diag_byte
);
    localparam int CW = $clog2(Q_DEPTH) + 1;

    // reset release through two flip-flops
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // control and sequence byte helpers used for apply and status
    function automatic logic lvl_out(input logic en, input logic lvl);
        lvl_out = en & lvl;
    endfunction : lvl_out

    function automatic logic [7:0] next_seq(input logic [7:0] s);
        next_seq = ((s & ets_pkg::SEQ_NUM_MASK) + 8'h01)
                   & ets_pkg::SEQ_NUM_MASK;
    endfunction : next_seq

    // queue signals
    ets_pkg::entry_s  in_entry;
    ets_pkg::entry_s  head;
    logic [31:0]      head_raw;
    logic             head_valid;
    logic             head_pop;
    logic             q_ready;
    logic [CW-1:0]    q_count;

    assign in_entry = ets_pkg::entry_s'(i_entry_data);
    assign head     = ets_pkg::entry_s'(head_raw);

    ets_fifo #(
        .WIDTH (ets_pkg::Q_WIDTH),
        .DEPTH (Q_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (rst_n_ff),
        .i_in_valid  (i_entry_wr),
        .o_in_ready  (q_ready),
        .i_in_data   (i_entry_data),
        .o_out_valid (head_valid),
        .i_out_ready (head_pop),
        .o_out_data  (head_raw),
        .o_count     (q_count)
    );

    wire [15:0] us_low   = i_us_ticker[15:0];
    wire        stamp_hit = head_valid && (us_low == head.stamp);

    // scheduler state
    ets_pkg::sched_e state_ff;
    ets_pkg::sched_e nxt_state;
    logic            en0_ff;
    logic            en1_ff;
    logic            do0_ff;
    logic            do1_ff;
    logic            nxt_en0;
    logic            nxt_en1;
    logic            nxt_do0;
    logic            nxt_do1;

    // only the head is ever applied
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ets_pkg::S_IDLE: begin
                if (head_valid) begin
                    nxt_state = ets_pkg::S_WAIT;
                end
            end
            ets_pkg::S_WAIT: begin
                if (stamp_hit) begin
                    nxt_state = ets_pkg::S_APPLY;
                end
            end
            ets_pkg::S_APPLY: begin
                nxt_state = ets_pkg::S_IDLE;
            end
            default: begin
                nxt_state = ets_pkg::S_IDLE;
            end
        endcase
    end

    assign head_pop = (state_ff == ets_pkg::S_APPLY);

    // enable bits taken from applied entry
    assign nxt_en0 = head_pop ? head.en0 : en0_ff;
    assign nxt_en1 = head_pop ? head.en1 : en1_ff;

    // bit 7 to output 0, bit 6 to output 1
    assign nxt_do0 = head_pop ? lvl_out(head.en0, head.lvl0) : do0_ff;
    assign nxt_do1 = head_pop ? lvl_out(head.en1, head.lvl1) : do1_ff;

    // scheduler and output registers
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= ets_pkg::S_IDLE;
            en0_ff   <= 1'b0;
            en1_ff   <= 1'b0;
            do0_ff   <= 1'b0;
            do1_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            en0_ff   <= nxt_en0;
            en1_ff   <= nxt_en1;
            do0_ff   <= nxt_do0;
            do1_ff   <= nxt_do1;
        end
    end

    // status image bookkeeping
    logic [7:0]  last_seq_ff;
    logic        last_mark_ff;
    logic        ready_ff;
    ets_pkg::status_s status_ff;
    ets_pkg::status_s nxt_status;
    wire         accepted = i_entry_wr && q_ready;
    wire         all_done = !head_valid;

    // a final-entry mark is latched, cleared by a later unmarked entry
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            last_seq_ff  <= 8'h00;
            last_mark_ff <= 1'b0;
        end else if (accepted) begin
            last_seq_ff  <= in_entry.seq;
            last_mark_ff <= in_entry.seq[ets_pkg::SEQ_LAST_BIT];
        end
    end

    // last, next, queue state and pending count
    always_comb begin
        nxt_status = '0;
        nxt_status.last_accepted_sequence = last_seq_ff;
        nxt_status.next_expected_sequence = next_seq(last_seq_ff);
        nxt_status.queue_state_byte[ets_pkg::QS_LAST_BIT] = last_mark_ff;
        nxt_status.queue_state_byte[ets_pkg::QS_BUSY_BIT] = !all_done;
        nxt_status.queue_state_byte[ets_pkg::QS_FULL_BIT] = !q_ready;
        nxt_status.pending_entry_count = 8'(q_count);
    end

    wire [7:0] out_len = LONG_VARIANT ? ets_pkg::OUT_LEN_L
                                      : ets_pkg::OUT_LEN_S;

    // status and length registers
    always_ff @(posedge i_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            status_ff             <= '0;
            ready_ff              <= 1'b0;
            o_input_image_length  <= 8'h00;
            o_output_image_length <= 8'h00;
        end else begin
            status_ff             <= nxt_status;
            ready_ff              <= q_ready;
            o_input_image_length  <= ets_pkg::IN_LEN;
            o_output_image_length <= out_len;
        end
    end

    // no interrupt output, record read only
    ets_diag u_diag (
        .i_clk    (i_clk),
        .i_rst_n  (rst_n_ff),
        .i_gen    (i_diag_gen),
        .i_ticker (i_us_ticker),
        .i_short  (i_diag_short),
        .i_idx    (i_diag_idx),
        .o_byte   (o_diag_byte)
    );

    // registered outputs
    assign o_do0         = do0_ff;
    assign o_do1         = do1_ff;
    assign o_input_image = status_ff;
    assign o_entry_ready = ready_ff;
endmodule : ets_sched
`default_nettype wire

/* File: testbench/ets_sched_props.sv */
/*
 checker of the scheduler ports.
 assumes it is bound to every ets_sched instance.
*/
`timescale 1ns/1ps
`default_nettype none
module ets_sched_props #(
    parameter bit LONG_VARIANT = 1'b0,
    parameter int Q_DEPTH      = 16
) (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_entry_wr,
    input wire logic [31:0] i_entry_data,
    input wire logic        o_entry_ready,
    input wire logic [31:0] i_us_ticker,
    input wire logic        o_do0,
    input wire logic        o_do1,
    input wire logic [31:0] o_input_image,
    input wire logic [7:0]  o_input_image_length,
    input wire logic [7:0]  o_output_image_length,
    input wire logic        i_diag_gen,
    input wire logic        i_diag_short,
    input wire logic [4:0]  i_diag_idx,
    input wire logic [7:0]  o_diag_byte
);
    logic [1:0] rdy_cnt_ff;
    wire        up  = (rdy_cnt_ff == 2'h3);
    wire [7:0]  cnt = o_input_image[7:0];
    wire [7:0]  qs  = o_input_image[15:8];
    wire [7:0]  lst = o_input_image[31:24];
    // counts edges after reset release
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) rdy_cnt_ff <= 2'h0;
        else if (!up) rdy_cnt_ff <= rdy_cnt_ff + 2'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_in_len_fixed: assert property (up |-> o_input_image_length == 8'h04)
        else $error("input image length wrong");
    a_out_len_fixed: assert property (up |->
        o_output_image_length == (LONG_VARIANT ? 8'h3C : 8'h14)) else $error("output length wrong");
    a_diag_class: assert property (up && $past(i_diag_idx) == 5'h01 |-> o_diag_byte == 8'h1F)
        else $error("module class byte wrong");
    a_diag_kind: assert property (up && !$past(i_diag_short) && $past(i_diag_idx) == 5'h04
        |-> o_diag_byte == 8'h72) else $error("channel kind byte wrong");
    a_diag_chans: assert property (up && !$past(i_diag_short) && $past(i_diag_idx) == 5'h06
        |-> o_diag_byte == 8'h02) else $error("channel count byte wrong");
    a_diag_short: assert property (up && $past(i_diag_short) && $past(i_diag_idx) > 5'h03
        |-> o_diag_byte == 8'h00) else $error("short record too long");
    a_diag_rsvd: assert property (up && ($past(i_diag_idx) inside {5'h00, 5'h02, 5'h03,
        [5'h05:5'h05], [5'h07:5'h0F]}) |-> o_diag_byte == 8'h00) else $error("reserved not zero");
    a_do_pop: assert property (up && ($changed(o_do0) || $changed(o_do1))
        |=> cnt < $past(cnt)) else $error("output changed without pop");
    a_seq_next: assert property (up && lst != 8'h00
        |-> o_input_image[23:16] == (((lst & 8'h3F) + 8'h01) & 8'h3F)) else $error("next seq wrong");
    a_pend_flags: assert property (up |-> qs[1] == (cnt != 8'h00)
        && qs[0] == (cnt == Q_DEPTH[7:0])) else $error("queue flags wrong");
    a_last_flag: assert property (up |-> qs[7] == lst[6])
        else $error("last flag wrong");
endmodule : ets_sched_props
bind ets_sched ets_sched_props #(.LONG_VARIANT(LONG_VARIANT), .Q_DEPTH(Q_DEPTH)) i_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_entry_wr(i_entry_wr),
    .i_entry_data(i_entry_data), .o_entry_ready(o_entry_ready), .i_us_ticker(i_us_ticker),
    .o_do0(o_do0), .o_do1(o_do1), .o_input_image(o_input_image),
    .o_input_image_length(o_input_image_length), .o_output_image_length(o_output_image_length),
    .i_diag_gen(i_diag_gen), .i_diag_short(i_diag_short), .i_diag_idx(i_diag_idx),
    .o_diag_byte(o_diag_byte));
`default_nettype wire

/* File: testbench/ets_ticker_model.sv */
/*
 head module model: a 32-bit microsecond ticker.
 assumes the bench loads and pauses it at will.
*/
`timescale 1ns/1ps
`default_nettype none
module ets_ticker_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_run,
    input  wire logic        i_load,
    input  wire logic [31:0] i_load_val,
    output logic [31:0]      o_ticker
);
    logic [1:0] pre_ff;
    // ticker steps once every four clocks
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_ff   <= 2'h0;
            o_ticker <= 32'h0;
        end else if (i_load) begin
            pre_ff   <= 2'h0;
            o_ticker <= i_load_val;
        end else if (i_run) begin
            pre_ff <= pre_ff + 2'h1;
            if (pre_ff == 2'h3) o_ticker <= o_ticker + 32'h1;
        end
    end
endmodule : ets_ticker_model
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
 self-checking bench of the timed output scheduler.
 assumes the ticker model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, gen = 1'b0, dshort = 1'b0;
    logic        run = 1'b1, ld = 1'b0, do0, do1, rdy;
    logic [31:0] data = 32'h0, ldv = 32'h0, tick, img;
    logic [4:0]  idx = 5'h00;
    logic [7:0]  inl, outl, db;
    int          bad_count = 0, samples_checked = 0;
    always #10 i_clk = ~i_clk;
    ets_ticker_model i_tick (.i_clk(i_clk), .i_rst_n(rst_n), .i_run(run), .i_load(ld),
        .i_load_val(ldv), .o_ticker(tick));
    ets_sched i_dut (.i_clk(i_clk), .i_reset_n(rst_n), .i_entry_wr(wr), .i_entry_data(data),
        .o_entry_ready(rdy), .i_us_ticker(tick), .o_do0(do0), .o_do1(do1), .o_input_image(img),
        .o_input_image_length(inl), .o_output_image_length(outl), .i_diag_gen(gen),
        .i_diag_short(dshort), .i_diag_idx(idx), .o_diag_byte(db));
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task put(input logic [31:0] d);
        @(negedge i_clk);
        wr = 1'b1;
        data = d;
    endtask : put
    task stop_wr;
        @(negedge i_clk);
        wr = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask : stop_wr
    task set_tick(input logic [31:0] v);
        @(negedge i_clk);
        ld = 1'b1;
        ldv = v;
        @(negedge i_clk);
        ld = 1'b0;
    endtask : set_tick
    task wait_tick(input logic [31:0] v);
        int n;
        n = 0;
        while (tick !== v && n < 4000) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 4000) bad_count++;
        repeat (3) @(negedge i_clk);
    endtask : wait_tick
    function logic [7:0] exp_diag(input logic [4:0] i, input logic s, input logic [31:0] ts);
        if (s && i > 5'h03) return 8'h00;
        case (i)
            5'h01: return 8'h1F;
            5'h04: return 8'h72;
            5'h06: return 8'h02;
            5'h10: return ts[7:0];
            5'h11: return ts[15:8];
            5'h12: return ts[23:16];
            5'h13: return ts[31:24];
            default: return 8'h00;
        endcase
    endfunction : exp_diag
    task rd_diag(input logic [4:0] i, input logic s);
        @(negedge i_clk);
        idx = i;
        dshort = s;
        @(negedge i_clk);
        chk({24'h0, db}, {24'h0, exp_diag(i, s, 32'hA1B2C3D4)});
    endtask : rd_diag
    // watchdog against a hang
    initial begin
        #400000;
        bad_count++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (16) @(negedge i_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        // length record only read, never rewritten while running
        chk({16'h0, inl, outl}, 32'h0000_0414);
        set_tick(32'h0000_0100);
        put(32'hF001_0110);
        put(32'hB002_0120);
        put(32'h7043_0130);
        stop_wr;
        chk(img, 32'h4304_8203);
        chk({30'h0, do0, do1}, 32'h0000_0000);
        wait_tick(32'h0000_0111);
        chk({30'h0, do0, do1}, 32'h0000_0003);
        wait_tick(32'h0000_0121);
        chk({30'h0, do0, do1}, 32'h0000_0002);
        wait_tick(32'h0000_0131);
        chk({30'h0, do0, do1}, 32'h0000_0001);
        chk(img, 32'h4304_8000);
        set_tick(32'h0000_FFF0);
        put(32'hE005_FFFF);
        put(32'h0046_0001);
        stop_wr;
        wait_tick(32'h0001_0000);
        chk({30'h0, do0, do1}, 32'h0000_0002);
        wait_tick(32'h0001_0002);
        chk({30'h0, do0, do1}, 32'h0000_0000);
        set_tick(32'h0000_1000);
        for (int k = 0; k < 17; k++) put({8'h30, 8'h01 + k[7:0], 16'h2000 + k[15:0]});
        stop_wr;
        chk(img, 32'h1011_0310);
        chk({31'h0, rdy}, 32'h0000_0000);
        set_tick(32'h0000_1FFE);
        wait_tick(32'h0000_2011);
        chk(img, 32'h1011_0000);
        run = 1'b0;
        set_tick(32'hA1B2C3D4);
        @(negedge i_clk);
        gen = 1'b1;
        @(negedge i_clk);
        gen = 1'b0;
        for (int i = 0; i < 22; i++) rd_diag(i[4:0], 1'b0);
        for (int i = 0; i < 8; i++) rd_diag(i[4:0], 1'b1);
        test_done;
    end
endmodule : tb_top
`default_nettype wire
